/* logic/cml_macrocell.sv */
// One output macrocell: combinatorial path or D, T, J-K, S-R register.
// Assumes product terms, pin value and clock pin arrive on clk_sys.
`timescale 1ns/1ps
module cml_macrocell (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire cml_pkg::cml_cfg_s cfg, // Macrocell configuration.
  input wire logic [7:0] sum_terms, // Eight sum product terms.
  input wire logic clkoe_term, // Clock or output enable term.
  input wire logic arst_term, // Register clear term.
  input wire logic bank_clk, // Synchronised bank clock pin.
  input wire logic pin_val, // Synchronised pin value.
  input wire logic preload, // Load register from pin.
  input wire logic por_hold, // Power-up clear in progress.
  output logic q, // Register state.
  output logic out_val, // Value for the pin.
  output logic out_en, // Pin drive enable.
  output logic fb // Feedback into the array.
);
  import cml_pkg::*;

  logic q_reg, q_next;
  logic bank_prev_reg, term_prev_reg;
  wire logic [7:0] split_mask = 8'((9'h001 << cfg.split_n) - 9'h001);
  wire logic sum_or = |sum_terms;
  wire logic d_val = sum_or ^ cfg.pol_a;
  wire logic a_in = (|(sum_terms & split_mask)) ^ cfg.pol_a;
  wire logic b_in = (|(sum_terms & ~split_mask)) ^ cfg.pol_b;
  wire logic is_comb = (cfg.mode == CML_MODE_COMB);
  wire logic bank_rise = bank_clk & ~bank_prev_reg;
  wire logic term_rise = clkoe_term & ~term_prev_reg;
  wire logic clk_edge = cfg.clk_term ? term_rise : bank_rise;
  wire logic clr = rst | por_hold | arst_term;

  always_comb begin
    q_next = q_reg;
    case (cfg.mode)
      CML_MODE_D: q_next = d_val;
      CML_MODE_T: q_next = q_reg ^ d_val;
      CML_MODE_JK: q_next = (a_in & ~q_reg) | (~b_in & q_reg);
      CML_MODE_SR: begin
        if (a_in & ~b_in) begin
          q_next = 1'b1;
        end else if (b_in & ~a_in) begin
          q_next = 1'b0;
        end
      end
      default: q_next = q_reg;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    bank_prev_reg <= rst ? 1'b0 : bank_clk;
    term_prev_reg <= rst ? 1'b0 : clkoe_term;
    if (clr) begin
      q_reg <= 1'b0;
    end else if (preload) begin
      q_reg <= pin_val;
    end else if (clk_edge && !is_comb) begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
  assign out_val = (is_comb ? sum_or : q_reg) ^ cfg.out_inv;
  assign out_en = (is_comb || !cfg.clk_term) ? clkoe_term : 1'b1;
  assign fb = (is_comb || ((cfg.mode == CML_MODE_D || cfg.mode == CML_MODE_T) && cfg.fb_pin))
    ? pin_val : q_reg;

  wire logic load_ok = !clr && !preload && clk_edge;

  arst_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    arst_term |=> !q_reg) else $error("clear term did not clear register");
  d_capture_a: assert property (@(posedge clk_sys) disable iff (rst)
    (load_ok && cfg.mode == CML_MODE_D) |=> (q_reg == $past(d_val)))
    else $error("D register missed its data");
  t_toggle_a: assert property (@(posedge clk_sys) disable iff (rst)
    (load_ok && cfg.mode == CML_MODE_T) |=> (q_reg == ($past(q_reg) ^ $past(d_val))))
    else $error("T register wrong after edge");
  jk_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (load_ok && cfg.mode == CML_MODE_JK && a_in && !b_in) |=> q_reg)
    else $error("J-K register did not set");
  sr_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (load_ok && cfg.mode == CML_MODE_SR && b_in && !a_in) |=> !q_reg)
    else $error("S-R register did not clear");
  term_clk_oe_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!is_comb && cfg.clk_term) |-> out_en) else $error("term clocked output not enabled");
  preload_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
    (preload && !clr) |=> (q_reg == $past(pin_val))) else $error("preload value lost");
  hold_no_edge_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!clr && !preload && !clk_edge) |=> $stable(q_reg)) else $error("register moved off edge");

endmodule : cml_macrocell

/* logic/cml_pkg.sv */
// Shared constants and types for the configurable logic macrocell array.
// Assumes one system clock; all users import the whole package.
package cml_pkg;

  localparam int CML_NUM_MC = 16;
  localparam int CML_NUM_IN = 4;
  localparam int CML_NUM_BANK = 2;
  localparam int CML_MC_PER_BANK = 8;
  localparam int CML_SUM_TERMS = 8;
  localparam int CML_TERMS_PER_MC = 10;
  localparam int CML_TERM_CLKOE = 8;
  localparam int CML_TERM_ARST = 9;
  localparam int CML_NUM_TERMS = 160;
  localparam int CML_ARR_SIGS = 20;
  localparam int CML_TERM_W = 40;

  // Power-up clear time and the cycles it takes at the system clock.
  localparam int CML_CLK_PERIOD_NS = 20;
  localparam int CML_POR_TIME_NS = 1000;
  localparam int CML_POR_CYCLES = CML_POR_TIME_NS / CML_CLK_PERIOD_NS;

  // Register map: byte offsets, configuration base as address bits 11:6, array base in eight-byte words.
  localparam logic [11:0] CML_OFS_CTRL = 12'h000;
  localparam logic [11:0] CML_OFS_STATUS = 12'h004;
  localparam logic [5:0] CML_CFG_BASE_HI = 6'h01;
  localparam logic [8:0] CML_ARR_BASE_W = 9'h080;
  localparam logic [31:0] CML_RST_CFG = 32'h0000_0001;

  // Control register fields.
  localparam int CML_CTRL_PRELOAD = 0;
  localparam int CML_CTRL_ERASE = 1;
  localparam int CML_CTRL_SECURE = 2;

  // Status register fields.
  localparam int CML_ST_SECURE = 0;
  localparam int CML_ST_POR_DONE = 1;
  localparam int CML_ST_Q_LSB = 16;

  typedef enum logic [4:0] {
    CML_MODE_COMB = 5'h01,
    CML_MODE_D = 5'h02,
    CML_MODE_T = 5'h04,
    CML_MODE_JK = 5'h08,
    CML_MODE_SR = 5'h10
  } cml_mode_e;

  typedef struct packed {
    logic [3:0] split_n;
    logic pol_b;
    logic pol_a;
    logic out_inv;
    logic fb_pin;
    logic clk_term;
    cml_mode_e mode;
  } cml_cfg_s;

  localparam int CML_CFG_W = 14;

endpackage : cml_pkg

/* logic/cml_top.sv */
// Top of the configurable logic macrocell array with its APB configuration slave.
// Assumes pins and clock pins come from the board and are asynchronous to clk_sys.
//
// Contract
// - Sixteen macrocells, four inputs, two clock pins each serving eight macrocells.
// - Each macrocell gets eight product terms into a fixed OR.
// - Every array input is offered in true and complemented form.
// - Empty product term is high; true and complement together make it low.
// - Clock from bank pin or term; term gates enable only with pin clocking.
// - Combinatorial mode ORs all eight terms; clock term drives output enable.
// - Output inversion is selectable in combinatorial and registered modes.
// - D and T feed back register or pin; J-K and S-R feed register.
// - D mode captures the polarity adjusted OR on each rising edge.
// - T mode toggles when its input is high, holds when low.
// - J-K takes N terms for J, the rest for K, each polarity selectable.
// - J-K holds, clears, sets or toggles per its input pair.
// - S-R takes N terms for S, the rest for R, each polarity selectable.
// - S-R holds, clears or sets; S and R must never both be high.
// - Dedicated clear term forces the register low over clock and data.
// - All registers clear low within the power-up time after start.
// - Test preload loads any register state from the pins.
// - Security bit blocks readback and programming, keeps preload, clears on erase.
`timescale 1ns/1ps
module cml_top #(
  parameter int NUM_MC = cml_pkg::CML_NUM_MC, // Macrocell count.
  parameter int NUM_IN = cml_pkg::CML_NUM_IN // Dedicated input count.
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [11:0] paddr, // APB address.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  input wire logic [NUM_IN-1:0] ded_in, // Dedicated input pins.
  input wire logic [1:0] bank_clk_pin, // Bank clock pins.
  input wire logic [NUM_MC-1:0] io_in, // I/O pin levels.
  output logic [NUM_MC-1:0] io_out, // I/O pin drive values.
  output logic [NUM_MC-1:0] io_oe // I/O pin drive enables.
);
  import cml_pkg::*;

  // The array map below is laid out for the documented sizes only.
  if (NUM_MC != CML_NUM_MC || NUM_IN != CML_NUM_IN) begin : g_size_chk
    $error("array map is fixed at sixteen macrocells and four inputs");
  end

  // Pin synchronisers: the first stage is read only by the second.
  logic [NUM_IN-1:0] ded_s1_reg, ded_s2_reg;
  logic [1:0] bclk_s1_reg, bclk_s2_reg;
  logic [NUM_MC-1:0] io_s1_reg, io_s2_reg;

  always_ff @(posedge clk_sys) begin
    ded_s1_reg <= ded_in;
    ded_s2_reg <= ded_s1_reg;
    bclk_s1_reg <= bank_clk_pin;
    bclk_s2_reg <= bclk_s1_reg;
    io_s1_reg <= io_in;
    io_s2_reg <= io_s1_reg;
  end

  // Configuration storage.
  logic [CML_TERM_W-1:0] arr_reg [CML_NUM_TERMS];
  cml_cfg_s cfg_reg [CML_NUM_MC];
  logic secure_reg;
  logic preload_reg;
  logic [7:0] por_cnt_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic [NUM_MC-1:0] io_out_reg, io_oe_reg;

  // Power-up clear counter.
  localparam logic [7:0] POR_LAST = 8'(CML_POR_CYCLES);
  wire logic por_hold = (por_cnt_reg != POR_LAST);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      por_cnt_reg <= 8'h00;
    end else if (por_hold) begin
      por_cnt_reg <= por_cnt_reg + 8'h01;
    end
  end

  // APB decode.
  wire logic sel_ctrl = (paddr == CML_OFS_CTRL);
  wire logic sel_status = (paddr == CML_OFS_STATUS);
  wire logic sel_cfg = (paddr[11:6] == CML_CFG_BASE_HI) && (paddr[1:0] == 2'h0);
  wire logic [3:0] cfg_idx = paddr[5:2];
  wire logic [8:0] arr_idx = 9'(paddr[11:3] - CML_ARR_BASE_W);
  wire logic arr_half = paddr[2];
  wire logic sel_arr = (paddr[11:10] != 2'h0) && (arr_idx < 9'(CML_NUM_TERMS))
    && (paddr[1:0] == 2'h0);
  wire logic [7:0] arr_i = arr_idx[7:0];
  wire logic blocked = secure_reg && (sel_cfg || sel_arr);
  wire logic mapped = sel_ctrl || sel_status || sel_cfg || sel_arr;
  wire logic acc_err = !mapped || blocked;
  wire logic setup_acc = psel && penable && !pready_reg;
  wire logic commit = psel && penable && pready_reg;
  wire logic wr_ok = commit && pwrite && !acc_err;
  wire logic do_erase = wr_ok && sel_ctrl && pwdata[CML_CTRL_ERASE];
  wire logic preload_req = wr_ok && sel_ctrl && pwdata[CML_CTRL_PRELOAD];
  wire logic [3:0] split_in = (pwdata[13:10] > 4'h8) ? 4'h8 : pwdata[13:10];
  wire cml_cfg_s cfg_in = cml_cfg_s'({split_in, pwdata[9:0]});

  // Macrocell state for status readback.
  logic [NUM_MC-1:0] q_all;
  wire logic [31:0] status_word = {q_all, 14'h0000, ~por_hold, secure_reg};
  wire logic [31:0] cfg_word = {18'h00000, cfg_reg[cfg_idx]};
  wire logic [31:0] arr_word = arr_half ? {24'h000000, arr_reg[arr_i][39:32]}
    : arr_reg[arr_i][31:0];
  wire logic [31:0] rd_data = acc_err ? 32'h0000_0000
    : sel_status ? status_word
    : sel_cfg ? cfg_word
    : sel_arr ? arr_word
    : 32'h0000_0000;

  // Answer one cycle into the access phase.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (setup_acc) begin
      pready_reg <= 1'b1;
      pslverr_reg <= acc_err;
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // Security bit and preload strobe.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      secure_reg <= 1'b0;
      preload_reg <= 1'b0;
    end else begin
      if (do_erase) begin
        secure_reg <= 1'b0;
      end else if (wr_ok && sel_ctrl && pwdata[CML_CTRL_SECURE]) begin
        secure_reg <= 1'b1;
      end
      preload_reg <= preload_req;
    end
  end

  // Array and macrocell configuration writes; erase restores the blank state.
  always_ff @(posedge clk_sys) begin
    for (int t = 0; t < CML_NUM_TERMS; t++) begin
      if (rst || do_erase) begin
        arr_reg[t] <= 40'h00_0000_0000;
      end else if (wr_ok && sel_arr && arr_i == 8'(t)) begin
        if (arr_half) begin
          arr_reg[t][39:32] <= pwdata[7:0];
        end else begin
          arr_reg[t][31:0] <= pwdata;
        end
      end
    end
    for (int m = 0; m < CML_NUM_MC; m++) begin
      if (rst || do_erase) begin
        cfg_reg[m] <= cml_cfg_s'(CML_RST_CFG[CML_CFG_W-1:0]);
      end else if (wr_ok && sel_cfg && cfg_idx == 4'(m)) begin
        cfg_reg[m] <= cfg_in;
      end
    end
  end

  // Product term array.
  logic [NUM_MC-1:0] fb_all;
  wire logic [CML_ARR_SIGS-1:0] arr_sig = {fb_all, ded_s2_reg};
  wire logic [CML_TERM_W-1:0] literals = {~arr_sig, arr_sig};
  logic [CML_NUM_TERMS-1:0] pterm;

  genvar gt;
  generate
    for (gt = 0; gt < CML_NUM_TERMS; gt++) begin : g_term
      // empty is high, conflict is low.
      assign pterm[gt] = &(~arr_reg[gt] | literals);
      term_empty_a: assert property (@(posedge clk_sys) disable iff (rst)
        (arr_reg[gt] == '0) |-> pterm[gt]) else $error("empty product term not high");
      term_clash_a: assert property (@(posedge clk_sys) disable iff (rst)
        (|(arr_reg[gt][19:0] & arr_reg[gt][39:20])) |-> !pterm[gt])
        else $error("conflicting product term not low");
    end
  endgenerate

  logic [NUM_MC-1:0] out_all, oe_all;
  genvar gm;
  generate
    for (gm = 0; gm < CML_NUM_MC; gm++) begin : g_mc
      localparam int B = gm * CML_TERMS_PER_MC;
      cml_macrocell u_mc (
        .clk_sys(clk_sys),
        .rst(rst),
        .cfg(cfg_reg[gm]),
        .sum_terms(pterm[B+CML_SUM_TERMS-1:B]),
        .clkoe_term(pterm[B+CML_TERM_CLKOE]),
        .arst_term(pterm[B+CML_TERM_ARST]),
        .bank_clk(bclk_s2_reg[gm / CML_MC_PER_BANK]),
        .pin_val(io_s2_reg[gm]),
        .preload(preload_reg),
        .por_hold(por_hold),
        .q(q_all[gm]),
        .out_val(out_all[gm]),
        .out_en(oe_all[gm]),
        .fb(fb_all[gm])
      );
    end
  endgenerate

  // Pin outputs are registered; drive stays off during reset.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      io_out_reg <= '0;
      io_oe_reg <= '0;
    end else begin
      io_out_reg <= out_all;
      io_oe_reg <= oe_all;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign io_out = io_out_reg;
  assign io_oe = io_oe_reg;

  // Helper snapshot of the addressed term for the security check.
  logic [CML_TERM_W-1:0] arr_seen;
  assign arr_seen = arr_reg[arr_i];

  por_regs_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    por_hold |-> (q_all == '0)) else $error("register not low during power-up clear");
  por_time_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> ##[1:51] !por_hold) else $error("power-up clear too long");
  secure_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (commit && pwrite && secure_reg && sel_arr && !$past(do_erase))
    |=> (arr_seen == $past(arr_seen))) else $error("secured array was written");
  secure_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_acc && secure_reg && (sel_arr || sel_cfg)) |=> (pslverr && prdata == 32'h0000_0000))
    else $error("secured array was read back");
  erase_unsecure_a: assert property (@(posedge clk_sys) disable iff (rst)
    do_erase |=> !secure_reg) else $error("erase left security set");
  secure_cfg_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    (commit && pwrite && secure_reg && sel_cfg) |=> $stable(cfg_reg[cfg_idx]))
    else $error("secured configuration was written");

  // Write landing and readback fields.
  arr_low_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ok && sel_arr && !arr_half) |=> (arr_seen[31:0] == $past(pwdata)))
    else $error("array low word write lost");
  arr_high_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ok && sel_arr && arr_half) |=> (arr_seen[39:32] == 8'($past(pwdata))))
    else $error("array high word write lost");
  cfg_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ok && sel_cfg) |=> (cfg_reg[cfg_idx][9:0] == 10'($past(pwdata))))
    else $error("configuration write lost");
  split_clamp_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ok && sel_cfg) |=> (cfg_reg[cfg_idx].split_n <= 4'h8))
    else $error("split count above eight stored");
  status_q_a: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_acc && sel_status && !pwrite) |=> (prdata[31:16] == $past(q_all)))
    else $error("status shows wrong register states");
  ctrl_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_acc && sel_ctrl && !pwrite) |=> (prdata == 32'h0000_0000))
    else $error("control register read not zero");

  // APB answer timing and qualification.
  apb_ready_time_a: assert property (@(posedge clk_sys) disable iff (rst)
    setup_acc |=> pready)
    else $error("ready did not follow the access phase");
  apb_ready_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    pready |=> !pready)
    else $error("ready stood longer than one cycle");
  apb_err_qual_a: assert property (@(posedge clk_sys) disable iff (rst)
    pslverr |-> pready)
    else $error("error shown without ready");
  apb_unmapped_a: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_acc && !mapped) |=> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  apb_ok_a: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_acc && !acc_err) |=> !pslverr)
    else $error("mapped access refused");
  apb_wr_rdata_a: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_acc && pwrite) |=> (prdata == 32'h0000_0000))
    else $error("write returned read data");

  // Pins follow the macrocells one cycle late and stay off through reset.
  pin_reg_a: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> (io_out == $past(out_all) && io_oe == $past(oe_all)))
    else $error("pin registers do not follow the macrocells");
  pin_reset_a: assert property (@(posedge clk_sys)
    rst |=> (io_oe == '0 && io_out == '0))
    else $error("pins driven during reset");

  // Preload strobe, security and power-up clear bookkeeping.
  preload_req_a: assert property (@(posedge clk_sys) disable iff (rst)
    preload_req |=> preload_reg)
    else $error("preload request not applied");
  preload_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    preload_reg |=> !preload_reg)
    else $error("preload strobe stood too long");
  secure_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ok && sel_ctrl && pwdata[CML_CTRL_SECURE] && !do_erase) |=> secure_reg)
    else $error("security bit not set");
  erase_cfg_a: assert property (@(posedge clk_sys) disable iff (rst)
    do_erase |=> (cfg_reg[cfg_idx] == cml_cfg_s'(CML_RST_CFG[CML_CFG_W-1:0])))
    else $error("erase left a configuration");
  por_stay_a: assert property (@(posedge clk_sys) disable iff (rst)
    !por_hold |=> !por_hold)
    else $error("power-up clear restarted");

  // Per-macrocell output, enable and feedback checks against the terms and register of each cell.
  genvar ga;
  generate
    for (ga = 0; ga < CML_NUM_MC; ga++) begin : g_chk
      localparam int C = ga * CML_TERMS_PER_MC;
      wire logic comb_sel = (cfg_reg[ga].mode == CML_MODE_COMB);
      wire logic sum_hit = |pterm[C+CML_SUM_TERMS-1:C];
      comb_or_a: assert property (@(posedge clk_sys) disable iff (rst)
        comb_sel |-> (out_all[ga] == (sum_hit ^ cfg_reg[ga].out_inv)))
        else $error("combinatorial output is not the term OR");
      comb_oe_a: assert property (@(posedge clk_sys) disable iff (rst)
        comb_sel |-> (oe_all[ga] == pterm[C+CML_TERM_CLKOE]))
        else $error("combinatorial enable is not the clock term");
      reg_out_a: assert property (@(posedge clk_sys) disable iff (rst)
        !comb_sel |-> (out_all[ga] == (q_all[ga] ^ cfg_reg[ga].out_inv)))
        else $error("registered output polarity wrong");
      reg_fb_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg_reg[ga].mode == CML_MODE_JK || cfg_reg[ga].mode == CML_MODE_SR)
        |-> (fb_all[ga] == q_all[ga])) else $error("J-K or S-R feedback not the register");
      pin_oe_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!comb_sel && !cfg_reg[ga].clk_term) |-> (oe_all[ga] == pterm[C+CML_TERM_CLKOE]))
        else $error("pin clocked enable is not the clock term");
    end
  endgenerate

endmodule : cml_top

/* tb/cml_board.sv */
// Board model: dedicated inputs, bank clock pins and resolved I/O pin levels.
// Assumes its tasks are called just after a rising edge of clk_sys.
`timescale 1ns/1ps
module cml_board (
  input wire logic clk_sys, // System clock.
  input wire logic [15:0] io_out, // Device pin values.
  input wire logic [15:0] io_oe, // Device pin enables.
  output logic [3:0] ded_in, // Dedicated inputs.
  output logic [1:0] bank_clk_pin, // Bank clocks.
  output logic [15:0] io_in // Pin levels.
);
  logic [15:0] drv = 16'h0000;
  initial begin
    ded_in = 4'h0;
    bank_clk_pin = 2'h0;
  end
  // The board drives a pin only where the device has released it.
  assign io_in = (io_oe & io_out) | (~io_oe & drv);
  task automatic set_ded(input logic [3:0] v);
    ded_in <= v;
  endtask : set_ded
  task automatic set_pins(input logic [15:0] v);
    drv <= v;
  endtask : set_pins
  // Both bank clocks rise together; they stand low between pulses.
  task automatic pulse();
    bank_clk_pin <= 2'h3;
    repeat (4) @(posedge clk_sys);
    bank_clk_pin <= 2'h0;
    repeat (4) @(posedge clk_sys);
  endtask : pulse
endmodule : cml_board

/* tb/cml_top_tb.sv */
// Self-checking bench for cml_top with a behavioural register model.
// Assumes cml_board drives the pins; one process runs the APB master.
`timescale 1ns/1ps
module cml_top_tb;
  import cml_pkg::*;
  localparam logic [31:0] CTR = 32'h0010_0001;
  logic clk_sys;
  logic rst;
  logic [11:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, rd_err, pa, pb;
  logic [31:0] pwdata, prdata, rd_val;
  logic [3:0] ded_in, v;
  logic [1:0] bank_clk_pin;
  logic [15:0] io_in, io_out, io_oe, mq, drv;
  int miscompares = 0;
  int checks = 0;
  cml_top uut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ded_in(ded_in), .bank_clk_pin(bank_clk_pin), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe));
  cml_board brd (.clk_sys(clk_sys), .io_out(io_out), .io_oe(io_oe), .ded_in(ded_in),
    .bank_clk_pin(bank_clk_pin), .io_in(io_in));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic end_of_test();
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dv);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dv;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) miscompares++;
  endtask : apb
  function automatic logic [31:0] cf(cml_mode_e md, logic ct, inv, a, b, logic [3:0] n);
    return {18'h0, n, b, a, inv, 1'b0, ct, md};
  endfunction : cf
  // Terms 1 to 6 are held low; the clear term follows input 3.
  task automatic prog(input int m, input logic [31:0] cfg, t0, t7, t8);
    for (int k = 0; k < 10; k++) begin
      apb(1'b1, 12'(12'h400 + 80 * m + 8 * k),
        k == 0 ? t0 : k == 7 ? t7 : k == 8 ? t8 : k == 9 ? 32'h0000_0008 : CTR);
    end
    apb(1'b1, 12'(12'h040 + 4 * m), cfg);
  endtask : prog
  task automatic rdq(input logic [15:0] m);
    apb(1'b0, CML_OFS_STATUS, 32'h0);
    chk("q", {16'h0, rd_val[31:16] & m}, {16'h0, mq & m});
  endtask : rdq
  task automatic step(input logic [1:0] dv);
    logic j, k, s, r;
    brd.set_ded({2'b00, dv});
    repeat (4) @(posedge clk_sys);
    brd.set_ded({2'b01, dv});
    brd.pulse();
    repeat (4) @(posedge clk_sys);
    j = dv[0] ^ pa;
    k = dv[1] ^ pb;
    s = dv[0] & dv[1];
    r = ~dv[0] & ~dv[1];
    mq[1] = dv[0] ^ pa;
    mq[2] = mq[2] ^ dv[1] ^ pa;
    mq[3] = (j & k) ? ~mq[3] : j ? 1'b1 : k ? 1'b0 : mq[3];
    mq[8] = s ? 1'b1 : r ? 1'b0 : mq[8];
    mq[9] = dv[1];
    rdq(16'h030E);
    chk("fb", {31'h0, io_out[4]}, {31'h0, mq[1]});
  endtask : step
  initial begin
    #400000;
    miscompares++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mq = 16'h0;
    void'($urandom(47598));
    pa = 1'($urandom());
    pb = 1'($urandom());
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (CML_POR_CYCLES + 5) @(posedge clk_sys);
    apb(1'b0, CML_OFS_STATUS, 32'h0);
    chk("status", rd_val, 32'h0000_0002);
    chk("pins", {io_oe, io_out}, 32'hFFFF_FFFF);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {31'h0, rd_err}, 32'h1);
    for (int inv = 0; inv < 2; inv++) begin
      prog(0, cf(CML_MODE_COMB, 1'b0, 1'(inv), 1'b0, 1'b0, 4'h0), 32'h1, 32'h0020_0000, 32'h4);
      for (int i = 0; i < 6; i++) begin
        v = 4'($urandom() % 8);
        brd.set_ded(v);
        repeat (6) @(posedge clk_sys);
        chk("comb", {io_oe[0], io_out[0]}, {v[2], (v[0] | ~v[1]) ^ 1'(inv)});
      end
    end
    prog(1, cf(CML_MODE_D, 1'b0, 1'b0, pa, 1'b0, 4'h0), 32'h1, CTR, CTR);
    prog(2, cf(CML_MODE_T, 1'b0, 1'b0, pa, 1'b0, 4'h0), 32'h2, CTR, CTR);
    prog(3, cf(CML_MODE_JK, 1'b0, 1'b0, pa, pb, 4'h7), 32'h1, 32'h2, CTR);
    // set and reset terms exclude each other
    prog(8, cf(CML_MODE_SR, 1'b0, 1'b0, 1'b0, 1'b0, 4'h7), 32'h3, 32'h0030_0000, CTR);
    prog(9, cf(CML_MODE_D, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0), 32'h2, CTR, 32'h4);
    // Cell 4 shows the register feedback of cell 1 on its pin.
    prog(4, cf(CML_MODE_COMB, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0), 32'h20, CTR, 32'h0);
    brd.set_ded(4'h8);
    repeat (6) @(posedge clk_sys);
    brd.set_ded(4'h0);
    repeat (4) @(posedge clk_sys);
    chk("oe", {io_oe[9], io_oe[1]}, 2'b10);
    for (int i = 0; i < 16; i++) step(2'($urandom()));
    brd.set_ded(4'h8);
    brd.pulse();
    mq = 16'h0;
    rdq(16'h030E);
    brd.set_ded(4'h0);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, CML_OFS_CTRL, {29'h0, 1'(s), 2'b00});
      drv = 16'($urandom());
      brd.set_pins(drv);
      repeat (4) @(posedge clk_sys);
      apb(1'b1, CML_OFS_CTRL, 32'h1);
      repeat (4) @(posedge clk_sys);
      mq = drv & 16'h010E;
      rdq(16'h030E);
    end
    apb(1'b0, CML_OFS_STATUS, 32'h0);
    chk("secure", {30'h0, rd_val[1:0]}, 32'h3);
    apb(1'b0, 12'h044, 32'h0);
    chk("sec_rd", {rd_err, rd_val[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h400, 32'h1);
    chk("sec_wr", {31'h0, rd_err}, 32'h1);
    apb(1'b1, CML_OFS_CTRL, 32'h2);
    apb(1'b0, 12'h044, 32'h0);
    chk("erased", {rd_err, rd_val[30:0]}, 32'h1);
    apb(1'b0, CML_OFS_STATUS, 32'h0);
    chk("unsec", {31'h0, rd_val[0]}, 32'h0);
    repeat (6) @(posedge clk_sys);
    chk("pins", {io_oe, io_out}, 32'hFFFF_FFFF);
    end_of_test();
  end
endmodule : cml_top_tb
